// *** src/paf_chan_mem.sv ***
// sixteen-word store of the latest sample of each input channel
`timescale 1ns/1ps
module paf_chan_mem (
  input  wire logic        aclk,
  input  wire logic        ce,
  input  wire logic        we,
  input  wire logic [3:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  raddr,
  output logic      [31:0] rdata
);
  logic [31:0] mem [16];

  always_ff @(posedge aclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// *** src/paf_pkg.sv ***
// constants and types for the pcm input speaker front end
// Behaviour
// - Word size never exceeds channel length; surplus trailing LSBs are dropped. Outside TDM the code stores no word when word size exceeds half the ratio.
// - Default polarity: falling frame clock starts channel 0, rising starts channel 1.
// - I2S captures the word MSB on the second active edge after a transition.
// - Left-justified captures the MSB on the first active edge after a transition.
// - One bit picks rising or falling bit clock as the sampling edge.
// - Polarity bit swaps which frame clock edge starts channel 0 or a TDM frame.
// - TDM carries up to 16 channels; I2S and left-justified carry two.
// - Default TDM polarity: rising frame clock is the frame sync.
// - TDM sub-mode 0, 1, 2 puts the first MSB on edge one, two, three.
// - Receive disabled feeds zero samples to the speaker path; the code passes one zero sample, then stops sampling.
// - Mono mixer passes one channel or mixes two, each source any of 16.
// - Event status bits latch on events and clear when status is read.
// - Frequency or framing fault on bit or frame clock sets clock error.
// - Dither enable adds one LSB peak-to-peak dither to the path input.
// - Inversion bit negates every sample entering the speaker path.
// - DC block enable inserts a high-pass filter in the path.
// - Volume attenuates 0 to -63 dB in 0.5 dB steps; code 0x7F mutes.
package paf_pkg;
  localparam int AW = 8;
  localparam logic [AW-1:0] OFF_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFF_MIX    = 8'h04;
  localparam logic [AW-1:0] OFF_SPK    = 8'h08;
  localparam logic [AW-1:0] OFF_STATUS = 8'h0C;
  localparam logic [AW-1:0] OFF_SAMPLE = 8'h10;
  // ctrl fields
  localparam int CT_RX_EN   = 0;
  localparam int CT_EDGE    = 1;
  localparam int CT_POL     = 2;
  localparam int CT_MODE    = 3;  // 2 bits
  localparam int CT_TDMSUB  = 5;  // 2 bits
  localparam int CT_WSIZE   = 7;  // 2 bits
  localparam int CT_RATIO   = 9;  // 10 bits
  localparam int CT_RATE    = 19; // 4 bits
  localparam logic [31:0] CTRL_RST = 32'h0000_8000;
  // mix fields
  localparam int MX_CFG  = 0;
  localparam int MX_SRCA = 4;
  localparam int MX_SRCB = 8;
  localparam logic [31:0] MIX_RST = 32'h0000_0100;
  // speaker fields
  localparam int SP_DITH = 0;
  localparam int SP_INV  = 1;
  localparam int SP_DC   = 2;
  localparam int SP_VOL  = 8;  // 7 bits
  localparam logic [31:0] SPK_RST = 32'h0000_0000;
  localparam logic [6:0] VOL_MUTE = 7'h7F;
  localparam logic [3:0] VOL_STEPS_PER_HALF = 4'hC;
  localparam int VOL_FRAC = 15;
  localparam int DC_SHIFT = 8;
  // status bits
  localparam int ST_CLK_ERR = 0;
  localparam int ST_SAMPLE  = 1;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  typedef enum logic [1:0] {
    PAF_I2S = 2'b00,
    PAF_LJ  = 2'b01,
    PAF_TDM = 2'b10
  } paf_mode_e;
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_RDA  = 6'b000010,
    S_RDB  = 6'b000100,
    S_PROC = 6'b001000,
    S_DC   = 6'b010000,
    S_VOL  = 6'b100000
  } paf_state_e;
endpackage

// *** src/paf_speaker_front.sv ***
// pcm receiver, mono mixer and speaker front end with axi4-lite registers
`timescale 1ns/1ps
module paf_speaker_front
  import paf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  input  wire logic        bit_clk,
  input  wire logic        frame_clk,
  input  wire logic        serial_data,
  output logic      [31:0] spk_sample,
  output logic             spk_valid
);
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  function automatic logic [31:0] sat(input logic signed [33:0] v);
    if (v > 34'sh0_7FFF_FFFF) sat = 32'h7FFF_FFFF;
    else if (v < -34'sh0_8000_0000) sat = 32'h8000_0000;
    else sat = v[31:0];
  endfunction

  // 0.5 dB per code step, Q15 mantissa
  function automatic logic [16:0] vol_mant(input logic [3:0] r);
    case (r)
      4'd0:    vol_mant = 17'd32768;
      4'd1:    vol_mant = 17'd30935;
      4'd2:    vol_mant = 17'd29205;
      4'd3:    vol_mant = 17'd27571;
      4'd4:    vol_mant = 17'd26029;
      4'd5:    vol_mant = 17'd24573;
      4'd6:    vol_mant = 17'd23198;
      4'd7:    vol_mant = 17'd21900;
      4'd8:    vol_mant = 17'd20675;
      4'd9:    vol_mant = 17'd19519;
      4'd10:   vol_mant = 17'd18427;
      default: vol_mant = 17'd17396;
    endcase
  endfunction

  // ---------------- registers and bus ----------------
  logic [31:0] ctrl_reg;
  logic [31:0] mix_reg;
  logic [31:0] spk_reg;
  logic        clk_err_reg;
  logic        done_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;

  wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire do_read  = s_axi_arvalid && s_axi_arready;
  wire wr_ctrl  = do_write && (awaddr_reg == OFF_CTRL);
  wire wr_mix   = do_write && (awaddr_reg == OFF_MIX);
  wire wr_spk   = do_write && (awaddr_reg == OFF_SPK);
  wire wr_ok    = (awaddr_reg == OFF_CTRL) || (awaddr_reg == OFF_MIX) ||
                  (awaddr_reg == OFF_SPK) || (awaddr_reg == OFF_STATUS) ||
                  (awaddr_reg == OFF_SAMPLE);
  wire rd_status = do_read && (s_axi_araddr == OFF_STATUS);
  wire rd_ok;
  wire [31:0] rd_val;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_arready = !s_axi_rvalid;

  assign rd_ok = (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_MIX) ||
                 (s_axi_araddr == OFF_SPK) || (s_axi_araddr == OFF_STATUS) ||
                 (s_axi_araddr == OFF_SAMPLE);
  assign rd_val =
    (s_axi_araddr == OFF_CTRL)   ? ctrl_reg :
    (s_axi_araddr == OFF_MIX)    ? mix_reg  :
    (s_axi_araddr == OFF_SPK)    ? spk_reg  :
    (s_axi_araddr == OFF_STATUS) ? {30'h0, done_reg, clk_err_reg} :
    (s_axi_araddr == OFF_SAMPLE) ? spk_sample : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end else if (ce) begin
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      mix_reg  <= MIX_RST;
      spk_reg  <= SPK_RST;
    end else if (ce) begin
      if (wr_ctrl) ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
      if (wr_mix)  mix_reg  <= merge(mix_reg, wdata_reg, wstrb_reg);
      if (wr_spk)  spk_reg  <= merge(spk_reg, wdata_reg, wstrb_reg);
    end
  end

  wire       rx_en    = ctrl_reg[CT_RX_EN];
  wire       edge_sel = ctrl_reg[CT_EDGE];
  wire       pol      = ctrl_reg[CT_POL];
  wire [1:0] mode     = ctrl_reg[CT_MODE +: 2];
  wire [1:0] tdm_sub  = ctrl_reg[CT_TDMSUB +: 2];
  wire [1:0] ws_sel   = ctrl_reg[CT_WSIZE +: 2];
  wire [9:0] ratio    = ctrl_reg[CT_RATIO +: 10];
  wire       is_tdm   = (mode == PAF_TDM);

  // ---------------- pin synchronisers ----------------
  logic bclk_s1, bclk_s2, bclk_s3;
  logic lr_s1, lr_s2;
  logic din_s1, din_s2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {bclk_s1, bclk_s2, bclk_s3} <= 3'b000;
      {lr_s1, lr_s2}              <= 2'b00;
      {din_s1, din_s2}            <= 2'b00;
    end else if (ce) begin
      {bclk_s3, bclk_s2, bclk_s1} <= {bclk_s2, bclk_s1, bit_clk};
      {lr_s2, lr_s1}              <= {lr_s1, frame_clk};
      {din_s2, din_s1}            <= {din_s1, serial_data};
    end
  end

  // ---------------- frame receiver ----------------
  logic       lr_prev_reg;
  logic [9:0] idx_reg;
  logic [9:0] fcnt_reg;
  logic [8:0] bit_reg;
  logic [3:0] chan_reg;
  logic       run_reg;
  logic       armed_reg;
  logic [31:0] sh_reg;
  logic       mix_go;

  wire act = edge_sel ? (bclk_s3 && !bclk_s2)
                      : (!bclk_s3 && bclk_s2);
  wire lr_e    = lr_s2 ^ pol;
  wire trans   = (lr_e != lr_prev_reg);
  wire start_ev = is_tdm ? (trans && lr_e) : trans;
  wire frame_ev = is_tdm ? (trans && lr_e)
                         : (trans && !lr_e);
  wire [9:0] idx = start_ev ? 10'd0
                 : ((idx_reg == 10'h3FF) ? idx_reg : idx_reg + 10'd1);
  wire [9:0] delay = (mode == PAF_LJ) ? 10'd0 :
                     is_tdm ? {8'h00, tdm_sub} :
                     10'd1;
  wire [5:0] ws = (ws_sel == 2'd0) ? 6'd16 :
                  (ws_sel == 2'd1) ? 6'd24 : 6'd32;
  wire [8:0] chlen = is_tdm ? {3'b000, ws} : ratio[9:1];
  wire       first = (idx == delay);
  wire       last_bit = (bit_reg == chlen - 9'd1);
  wire       run_now = first || run_reg;
  wire [8:0] bit_now = (first || last_bit) ? 9'd0 : bit_reg + 9'd1;
  wire [3:0] chan_now = first ? (is_tdm ? 4'd0 : {3'b000, lr_e})
                      : (last_bit ? chan_reg + 4'd1 : chan_reg);
  wire       chan_ok = is_tdm || (chan_now == chan_reg) || first;
  wire       cap = act && run_now && chan_ok &&
                   (bit_now < {3'b000, ws});
  wire [31:0] sh_next = {sh_reg[30:0], din_s2};
  wire       word_done = cap && (bit_now == {3'b000, ws} - 9'd1);
  wire [31:0] word_al = sh_next << (6'd32 - ws);
  wire [9:0] fcnt_next = (fcnt_reg == 10'h3FF) ? fcnt_reg
                                               : fcnt_reg + 10'd1;
  wire       clk_fault = act && frame_ev && armed_reg &&
                         (fcnt_next != ratio);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lr_prev_reg <= 1'b0;
      idx_reg     <= 10'h000;
      fcnt_reg    <= 10'h000;
      bit_reg     <= 9'h000;
      chan_reg    <= 4'h0;
      run_reg     <= 1'b0;
      armed_reg   <= 1'b0;
      sh_reg      <= 32'h0000_0000;
    end else if (ce && act) begin
      lr_prev_reg <= lr_e;
      idx_reg     <= idx;
      fcnt_reg    <= frame_ev ? 10'd0 : fcnt_next;
      if (frame_ev) armed_reg <= rx_en;
      if (run_now) begin
        bit_reg  <= bit_now;
        chan_reg <= chan_now;
        run_reg  <= chan_ok && !(last_bit && !first &&
                    (!is_tdm || chan_reg == 4'hF));
      end
      if (cap) sh_reg <= sh_next;
    end
  end

  assign mix_go = act && frame_ev && armed_reg;

  // ---------------- mixer and speaker path ----------------
  paf_state_e  st_reg;
  logic [31:0] a_reg;
  logic [31:0] acc_reg;
  logic [31:0] x1_reg;
  logic [31:0] y1_reg;
  logic [15:0] lfsr_reg;
  logic [31:0] rdata;
  logic        spk_valid_reg;

  wire [3:0] src_a  = mix_reg[MX_SRCA +: 4];
  wire [3:0] src_b  = mix_reg[MX_SRCB +: 4];
  wire       mix_two = mix_reg[MX_CFG];
  wire [3:0] raddr  = (st_reg == S_RDA) ? src_b : src_a;

  paf_chan_mem u_mem (
    .aclk  (aclk),
    .ce    (ce),
    .we    (word_done),
    .waddr (chan_now),
    .wdata (word_al),
    .raddr (raddr),
    .rdata (rdata)
  );

  wire signed [31:0] sa = a_reg;
  wire signed [31:0] sb = rdata;
  wire [31:0] mixed = !rx_en ? 32'h0000_0000 :
                      mix_two ? 32'(($signed(sa) >>> 1) +
                                    ($signed(sb) >>> 1)) :
                      a_reg;
  wire [31:0] lsb_w = 32'h0000_0001 << (6'd32 - ws);
  wire [31:0] dith  = (spk_reg[SP_DITH] && lfsr_reg[0])
                      ? sat(34'($signed(acc_reg)) + 34'($signed(lsb_w)))
                      : acc_reg;
  wire [31:0] inv   = !spk_reg[SP_INV] ? dith :
                      (dith == 32'h8000_0000) ? 32'h7FFF_FFFF :
                      32'(-$signed(dith));
  wire signed [33:0] dc_sum = 34'($signed(acc_reg)) -
                              34'($signed(x1_reg)) +
                              34'($signed(y1_reg)) -
                              34'($signed(y1_reg) >>> DC_SHIFT);
  wire [31:0] dc_y  = sat(dc_sum);
  wire [6:0]  vol   = spk_reg[SP_VOL +: 7];
  wire [3:0]  vol_sh = 4'(vol / 7'(VOL_STEPS_PER_HALF));
  wire [3:0]  vol_r  = 4'(vol % 7'(VOL_STEPS_PER_HALF));
  wire signed [49:0] prod = $signed(acc_reg) *
                            $signed({1'b0, vol_mant(vol_r)});
  wire signed [49:0] scaled = (prod >>> VOL_FRAC) >>> vol_sh;
  wire [31:0] vol_y = (vol == VOL_MUTE) ? 32'h0000_0000
                                        : scaled[31:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg        <= S_IDLE;
      a_reg         <= 32'h0000_0000;
      acc_reg       <= 32'h0000_0000;
      x1_reg        <= 32'h0000_0000;
      y1_reg        <= 32'h0000_0000;
      lfsr_reg      <= LFSR_SEED;
      spk_sample    <= 32'h0000_0000;
      spk_valid_reg <= 1'b0;
    end else if (ce) begin
      spk_valid_reg <= 1'b0;
      case (st_reg)
        S_IDLE: begin
          if (mix_go) st_reg <= S_RDA;
        end
        S_RDA: begin
          a_reg  <= rdata;
          st_reg <= S_RDB;
        end
        S_RDB: begin
          acc_reg <= mixed;
          st_reg  <= S_PROC;
        end
        S_PROC: begin
          acc_reg  <= inv;
          lfsr_reg <= {lfsr_reg[14:0],
                       lfsr_reg[15] ^ lfsr_reg[13] ^
                       lfsr_reg[12] ^ lfsr_reg[10]};
          st_reg   <= S_DC;
        end
        S_DC: begin
          if (spk_reg[SP_DC]) begin
            acc_reg <= dc_y;
            x1_reg  <= acc_reg;
            y1_reg  <= dc_y;
          end
          st_reg <= S_VOL;
        end
        S_VOL: begin
          spk_sample    <= vol_y;
          spk_valid_reg <= 1'b1;
          st_reg        <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  assign spk_valid = spk_valid_reg;

  // ---------------- event status, clear on read ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_err_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else if (ce) begin
      if (clk_fault) clk_err_reg <= 1'b1;
      else if (rd_status) clk_err_reg <= 1'b0;
      if (st_reg == S_VOL) done_reg <= 1'b1;
      else if (rd_status) done_reg <= 1'b0;
    end
  end
endmodule

// *** testbench/paf_pcm_host.sv ***
// behavioural host driving bit clock, frame clock and serial data
`timescale 1ns/1ps
module paf_pcm_host
  import paf_pkg::*;
(
  input  wire logic        run,
  input  wire logic [1:0]  mode,
  input  wire logic [1:0]  dly,
  input  wire logic        fall_act,
  input  wire logic        frame_inv,
  input  wire logic [9:0]  ratio,
  input  wire logic [15:0] base,
  output logic             bit_clk,
  output logic             frame_clk,
  output logic             serial_data
);
  logic        bc = 1'b0;
  logic        fc = 1'b0;
  logic        sd = 1'b0;
  logic        fa = 1'b0;
  logic        fi = 1'b0;
  logic [15:0] w;
  int          i, n, d, cl, p, b;
  always begin
    if (!run) begin
      bc = 1'b0;
      sd = ~sd;
      #400;
    end else begin
      fa = fall_act;
      fi = frame_inv;
      n = ratio;
      d = (mode == PAF_I2S) ? 1 : (mode == PAF_LJ) ? 0 : dly;
      cl = (mode == PAF_TDM) ? 16 : n / 2;
      for (i = 0; i < n; i++) begin
        bc = 1'b0;
        fc = (mode == PAF_TDM) ? (i == 0) : (i >= n / 2);
        p = (i + n - d) % n;
        b = p % cl;
        w = base + 16'(p / cl) * 16'h0101;
        sd = (b < 16) ? w[15-b] : ~sd;
        #400;
        bc = 1'b1;
        #400;
      end
    end
  end
  assign bit_clk     = bc ^ fa;
  assign frame_clk   = fc ^ fi;
  assign serial_data = sd;
endmodule

// *** testbench/paf_speaker_front_assertions.sv ***
// concurrent checks on the speaker front end ports
`timescale 1ns/1ps
module paf_speaker_front_assertions
  import paf_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] spk_sample,
  input wire logic        spk_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken ##0 !s_axi_bvalid
    |-> ##2 s_axi_bvalid)
    else $error("write not answered within two cycles");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  wr_release_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after response");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before taken");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  unmapped_read_a: assert property (rd_taken ##0 s_axi_araddr > OFF_SAMPLE
    |=> s_axi_rresp == RESP_ERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  sample_read_a: assert property (rd_taken ##0 s_axi_araddr == OFF_SAMPLE
    |=> s_axi_rdata == $past(spk_sample) && s_axi_rresp == RESP_OK)
    else $error("sample register differs from output");
  valid_pulse_a: assert property (spk_valid |=> !spk_valid)
    else $error("sample strobe longer than one cycle");
  sample_change_a: assert property (!$stable(spk_sample) |-> spk_valid)
    else $error("sample changed without strobe");
endmodule
bind paf_speaker_front paf_speaker_front_assertions u_chk (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .spk_sample(spk_sample), .spk_valid(spk_valid)
);

// *** testbench/tb_top.sv ***
// self-checking bench for the pcm speaker front end
`timescale 1ns/1ps
module tb_top
  import paf_pkg::*;
;
  localparam logic [15:0] BASE = 16'h3A50;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce      = 1'b1;
  logic        awv     = 1'b0;
  logic        wv      = 1'b0;
  logic        bready  = 1'b0;
  logic        arv     = 1'b0;
  logic        rready  = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        h_run   = 1'b0;
  logic        h_fall  = 1'b0;
  logic        h_inv   = 1'b0;
  logic [1:0]  h_mode  = PAF_I2S;
  logic [1:0]  h_dly   = 2'h0;
  logic [9:0]  h_ratio = 10'h040;
  logic        awready, wready, bvalid, arready, rvalid, spk_valid;
  logic        bclk, fclk, sdata;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, spk_sample, d;
  int          fails = 0;
  int          comparisons = 0;
  int          s;
  always #50 aclk = ~aclk;
  paf_speaker_front dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .bit_clk(bclk),
    .frame_clk(fclk), .serial_data(sdata), .spk_sample(spk_sample),
    .spk_valid(spk_valid)
  );
  paf_pcm_host host (
    .run(h_run), .mode(h_mode), .dly(h_dly), .fall_act(h_fall),
    .frame_inv(h_inv), .ratio(h_ratio), .base(BASE), .bit_clk(bclk),
    .frame_clk(fclk), .serial_data(sdata)
  );
  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic       ha, hw, hb;
    logic [1:0] br;
    hb = 1'b0;
    @(posedge aclk);
    awv <= 1'b1;
    awaddr <= a;
    wv <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    for (int n = 0; !hb; n++) begin
      if (n > 200) begin
        fails++;
        test_done();
      end
      @(negedge aclk);
      ha = awv && awready;
      hw = wv && wready;
      hb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end
    bready <= 1'b0;
    check({30'h0, br}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rr);
    logic ha, hr;
    hr = 1'b0;
    @(posedge aclk);
    arv <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; !hr; n++) begin
      if (n > 200) begin
        fails++;
        test_done();
      end
      @(negedge aclk);
      ha = arv && arready;
      hr = rvalid;
      v = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ha) arv <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic wait_samples(input int n);
    for (int k = 0; n > 0; k++) begin
      if (k > 6000) begin
        fails++;
        test_done();
      end
      @(negedge aclk);
      if (spk_valid === 1'b1) n--;
    end
  endtask
  function automatic logic [31:0] ctl(input logic f, input logic p,
      input logic [1:0] md, input logic [1:0] sb, input logic [9:0] ra);
    ctl = {13'h0, ra, 2'b00, sb, md, p, f, 1'b1};
  endfunction
  function automatic logic [31:0] wd(input int k);
    wd = {BASE + 16'(k) * 16'h0101, 16'h0000};
  endfunction
  task automatic scen(input logic [31:0] c, input logic [3:0] m,
                      input logic [31:0] sp);
    wr(OFF_CTRL, c, RESP_OK);
    wr(OFF_MIX, {20'h0, m[3:2] == 2'b11 ? 4'h3 : 4'h1,
                 m[3:2] == 2'b11 ? 4'h2 : {3'h0, m[1]}, 3'h0, m[0]}, RESP_OK);
    wr(OFF_SPK, sp, RESP_OK);
    wait_samples(4);
  endtask
  task automatic host_set(input logic [1:0] md, input logic [1:0] dl,
                          input logic f, input logic p, input logic [9:0] ra);
    h_mode <= md;
    h_dly <= dl;
    h_fall <= f;
    h_inv <= p;
    h_ratio <= ra;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CTRL, d, r);
    check(d, CTRL_RST);
    rd(OFF_MIX, d, r);
    check(d, MIX_RST);
    rd(OFF_SPK, d, r);
    check(d, SPK_RST);
    rd(8'h14, d, r);
    check({30'h0, r}, {30'h0, RESP_ERR});
    wr(8'h14, 32'hFFFF_FFFF, RESP_ERR);
    h_run <= 1'b1;
    scen(ctl(0, 0, PAF_I2S, 0, 64), 4'b0000, 0);
    check(spk_sample, wd(0));
    rd(OFF_SAMPLE, d, r);
    check(d, wd(0));
    scen(ctl(0, 0, PAF_I2S, 0, 64), 4'b0010, 0);
    check(spk_sample, wd(1));
    scen(ctl(0, 0, PAF_I2S, 0, 64), 4'b0001, 0);
    check(spk_sample, (wd(0) >> 1) + (wd(1) >> 1));
    host_set(PAF_LJ, 0, 1, 0, 64);
    scen(ctl(1, 0, PAF_LJ, 0, 64), 4'b0000, 0);
    check(spk_sample, wd(0));
    for (s = 0; s < 3; s++) begin
      host_set(PAF_TDM, 2'(s), 0, s == 2, 64);
      scen(ctl(0, s == 2, PAF_TDM, 2'(s), 64), 4'b1101, 0);
      check(spk_sample, (wd(2) >> 1) + (wd(3) >> 1));
    end
    host_set(PAF_I2S, 0, 0, 0, 64);
    scen(ctl(0, 0, PAF_I2S, 0, 64), 4'b0000, 32'h0000_0002);
    check(spk_sample, -wd(0));
    scen(ctl(0, 0, PAF_I2S, 0, 64), 4'b0000, {17'h0, VOL_MUTE, 8'h00});
    check(spk_sample, 32'h0000_0000);
    scen(ctl(0, 0, PAF_I2S, 0, 64), 4'b0000, 32'h0000_0001);
    check({31'h0, spk_sample - wd(0) <= 32'h0001_0000}, 32'h1);
    scen(ctl(0, 0, PAF_I2S, 0, 64), 4'b0000, 32'h0000_0004);
    check({31'h0, spk_sample !== wd(0)}, 32'h1);
    rd(OFF_STATUS, d, r);
    host_set(PAF_I2S, 0, 0, 0, 48);
    d = 32'h0;
    for (s = 0; s < 2000 && d[ST_CLK_ERR] !== 1'b1; s++) rd(OFF_STATUS, d, r);
    check({31'h0, d[ST_CLK_ERR]}, 32'h1);
    host_set(PAF_I2S, 0, 0, 0, 64);
    wait_samples(4);
    rd(OFF_STATUS, d, r);
    rd(OFF_STATUS, d, r);
    check({31'h0, d[ST_CLK_ERR]}, 32'h0);
    wait_samples(1);
    // clock enable low must freeze the sample path over two frames
    @(posedge aclk);
    ce <= 1'b0;
    s = 0;
    repeat (1100) begin
      @(negedge aclk);
      if (spk_valid === 1'b1) s++;
    end
    @(posedge aclk);
    ce <= 1'b1;
    check(s, 0);
    rd(OFF_STATUS, d, r);
    check({31'h0, d[ST_SAMPLE]}, 32'h1);
    wr(OFF_SPK, 32'h0000_0000, RESP_OK);
    wr(OFF_CTRL, ctl(0, 0, PAF_I2S, 0, 64) & 32'hFFFF_FFFE, RESP_OK);
    wait_samples(1);
    check(spk_sample, 32'h0000_0000);
    test_done();
  end
endmodule
